// ===== src/tccp_regs.vh
// Register indices, field positions and reset values of the timer group
`ifndef TCCP_REGS_VH
`define TCCP_REGS_VH

// Channel window: byte address = channel * 32 + index * 4
`define TCCP_NUM_CH 5
`define TCCP_CH_LSB 5
`define TCCP_IDX_LSB 2

// Register index inside a channel window
`define TCCP_IDX_CTRL 3'h0
`define TCCP_IDX_PAC 3'h1
`define TCCP_IDX_STATUS 3'h2
`define TCCP_IDX_CNT 3'h3
`define TCCP_IDX_GRA 3'h4
`define TCCP_IDX_GRB 3'h5
`define TCCP_IDX_GRD 3'h6

// Control register fields
`define TCCP_CTRL_CLR_HI 1
`define TCCP_CTRL_CLR_LO 0
`define TCCP_CTRL_SYNC 2
`define TCCP_CTRL_PWM1 3
`define TCCP_CTRL_COMP 4
`define TCCP_CTRL_RUN 5
`define TCCP_CTRL_W 6

// Counter clear source codes
`define TCCP_CLR_NONE 2'h0
`define TCCP_CLR_A 2'h1
`define TCCP_CLR_B 2'h2
`define TCCP_CLR_SYNC 2'h3

// Pin action code fields, one nibble per general register
`define TCCP_PAC_CAPTURE 3
`define TCCP_PAC_INIT 2
`define TCCP_PAC_W 12

// Status register fields
`define TCCP_ST_A 0
`define TCCP_ST_B 1
`define TCCP_ST_D 3
`define TCCP_ST_OVF 4
`define TCCP_ST_W 5

// Reset values
`define TCCP_CTRL_RST 6'h00
`define TCCP_PAC_RST 4'h0
`define TCCP_ST_RST 5'h00
`define TCCP_CNT_RST 16'h0000
`define TCCP_GR_RST 16'hffff
`define TCCP_CNT_MAX 16'hffff
`define TCCP_CNT_ONE 16'h0001

`endif

// ===== src/tccp_compare_unit.v
// One general register with its compare, capture and pin action logic
`timescale 1ns/10ps
`default_nettype none
`include "tccp_regs.vh"

module tccp_compare_unit (
  input wire clk,
  input wire rst,
  input wire code_wr,
  input wire [3:0] code_in,
  input wire gr_wr,
  input wire [15:0] gr_in,
  input wire [15:0] cnt,
  input wire run,
  input wire pin_in,
  input wire alt_en,
  input wire alt_match,
  input wire [3:0] alt_code,
  output wire [3:0] code,
  output wire [15:0] gr,
  output wire match,
  output wire cap,
  output reg pin_out,
  output reg pin_oe
);

  reg [3:0] code_reg;
  reg [15:0] gr_reg;
  reg prev_reg;

  // New pin level for an action code at a compare match
  function act_level;
    input [1:0] act;
    input lvl;
    begin
      case (act)
        2'h1: act_level = 1'b0;
        2'h2: act_level = 1'b1;
        2'h3: act_level = ~lvl;
        default: act_level = lvl;
      endcase
    end
  endfunction

  // Edge detector for the capture select
  function edge_hit;
    input [1:0] sel;
    input was;
    input now;
    begin
      case (sel)
        2'h0: edge_hit = ~was & now;
        2'h1: edge_hit = was & ~now;
        default: edge_hit = was ^ now;
      endcase
    end
  endfunction

  assign code = code_reg;
  assign gr = gr_reg;
  assign match = run & ~code_reg[`TCCP_PAC_CAPTURE] & (cnt == gr_reg);
  assign cap = run & code_reg[`TCCP_PAC_CAPTURE] &
    edge_hit(code_reg[1:0], prev_reg, pin_in);

  // Code, general register, pin state
  always @(posedge clk) begin
    if (rst) begin
      code_reg <= `TCCP_PAC_RST;
      gr_reg <= `TCCP_GR_RST;
      prev_reg <= 1'b0;
      pin_out <= 1'b0;
      pin_oe <= 1'b1;
    end else begin
      prev_reg <= pin_in;
      if (cap) begin
        gr_reg <= cnt;
      end else if (gr_wr) begin
        gr_reg <= gr_in;
      end
      if (code_wr) begin
        code_reg <= code_in;
        pin_oe <= ~code_in[`TCCP_PAC_CAPTURE];
        if (~code_in[`TCCP_PAC_CAPTURE] && code_in[1:0] != 2'h0) begin
          pin_out <= code_in[`TCCP_PAC_INIT];
        end
      end else if (match) begin
        pin_out <= act_level(code_reg[1:0], pin_out);
      end else if (alt_en && alt_match) begin
        pin_out <= act_level(alt_code[1:0], pin_out);
      end
    end
  end

endmodule
`default_nettype wire

// ===== src/tccp_timer_group.v
// Five channel 16-bit timer group with APB register access
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "tccp_regs.vh"

// Function
// - Output compare mode: low bits keep, drive low, drive high, toggle.
// - Non-zero compare action sets initial pin level from second bit.
// - Pin drives low after reset; action zero keeps the pin.
// - Capture mode: rising, falling, or both edges; second bit ignored.
// - Counter wrap from maximum to zero sets the overflow flag.
// - Channel 4 complementary mode underflow one to zero sets overflow.
// - Flags clear by writing zero after reading one; one is ignored.
// - Counter equal to register D in compare mode sets D flag.
// - Capture into register D sets the D flag.
// - D flag only in channels 0, 3, 4; else reads zero.
// - PWM mode 1: A sets period, B sets duty on pin A.
// - Channels 0 to 2 preset together and clear synchronously.
module tccp_timer_group (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [14:0] pin_in,
  output wire [14:0] pin_out,
  output wire [14:0] pin_oe
);

  wire [2:0] sel_ch;
  wire [2:0] sel_idx;
  wire mapped;
  wire setup_done;
  wire xfer;
  wire bus_wr;
  wire bus_rd_latch;
  wire [79:0] ch_rd;
  wire [4:0] cnt_wr;
  wire [4:0] sync_mem;
  wire [4:0] clr_out;
  reg [15:0] rd_mux;

  // Address decode: channel window and register index
  assign sel_ch = paddr[7:5];
  assign sel_idx = paddr[4:2];
  assign mapped = (paddr[31:8] == 24'h00_0000) && (paddr[1:0] == 2'h0) &&
    (sel_ch < 3'h5) && (sel_idx != 3'h7);
  assign setup_done = psel & penable & ~pready;
  assign xfer = psel & penable & pready;
  assign bus_wr = xfer & pwrite & mapped;
  assign bus_rd_latch = setup_done & ~pwrite & mapped;

  // Read data select from the addressed channel
  always @* begin
    case (sel_ch)
      3'h0: rd_mux = ch_rd[15:0];
      3'h1: rd_mux = ch_rd[31:16];
      3'h2: rd_mux = ch_rd[47:32];
      3'h3: rd_mux = ch_rd[63:48];
      3'h4: rd_mux = ch_rd[79:64];
      default: rd_mux = 16'h0000;
    endcase
  end

  // APB slave: one wait state, error on unmapped address
  always @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_done;
      // Error stands only with the ready pulse, also back to back
      pslverr <= setup_done & ~mapped;
      if (setup_done) begin
        prdata <= (mapped && !pwrite) ? {16'h0000, rd_mux} : 32'h0000_0000;
      end
    end
  end

  genvar g;
  genvar k;
  generate
    for (g = 0; g < `TCCP_NUM_CH; g = g + 1) begin : ch
      localparam [31:0] CH_NUM = g;
      localparam [2:0] CH_ID = CH_NUM[2:0];
      localparam HAS_D = (g == 0) || (g == 3) || (g == 4);
      localparam IS_SYNC = (g < 3);
      localparam HAS_COMP = (g == 4);
      localparam [5:0] CTRL_MASK = {1'b1, HAS_COMP ? 1'b1 : 1'b0, 1'b1,
        IS_SYNC ? 1'b1 : 1'b0, 2'h3};

      reg [5:0] ctrl_reg;
      reg [15:0] cnt_reg;
      reg [15:0] cnt_next;
      reg [4:0] flag_reg;
      reg [4:0] arm_reg;
      reg down_reg;
      reg down_next;
      reg ovf_ev;
      reg [15:0] rd_reg_val;
      wire wr_this;
      wire rd_this;
      wire st_wr;
      wire run;
      wire comp;
      wire [1:0] clr_src;
      wire [2:0] m;
      wire [2:0] c;
      wire [11:0] codes;
      wire [47:0] grs;
      wire own_clr;
      wire sync_in;
      wire ext_clr;
      wire preset;
      wire [4:0] set_vec;
      wire [4:0] clr_vec;

      assign wr_this = bus_wr && (sel_ch == CH_ID);
      assign rd_this = bus_rd_latch && (sel_ch == CH_ID);
      assign st_wr = wr_this && (sel_idx == `TCCP_IDX_STATUS);
      assign run = ctrl_reg[`TCCP_CTRL_RUN];
      assign comp = ctrl_reg[`TCCP_CTRL_COMP];
      assign clr_src = ctrl_reg[`TCCP_CTRL_CLR_HI:`TCCP_CTRL_CLR_LO];

      // General registers A, B, D with their pins
      for (k = 0; k < 3; k = k + 1) begin : unit
        localparam [2:0] GR_IDX = (k == 0) ? `TCCP_IDX_GRA :
          ((k == 1) ? `TCCP_IDX_GRB : `TCCP_IDX_GRD);
        tccp_compare_unit u_cmp (
          .clk(clk),
          .rst(rst),
          .code_wr(wr_this && (sel_idx == `TCCP_IDX_PAC)),
          .code_in(pwdata[4*k+3:4*k]),
          .gr_wr(wr_this && (sel_idx == GR_IDX)),
          .gr_in(pwdata[15:0]),
          .cnt(cnt_reg),
          .run(run),
          .pin_in(pin_in[3*g+k]),
          .alt_en((k == 0) && ctrl_reg[`TCCP_CTRL_PWM1]),
          .alt_match(m[1]),
          .alt_code(codes[7:4]),
          .code(codes[4*k+3:4*k]),
          .gr(grs[16*k+15:16*k]),
          .match(m[k]),
          .cap(c[k]),
          .pin_out(pin_out[3*g+k]),
          .pin_oe(pin_oe[3*g+k])
        );
      end

      assign sync_mem[g] = IS_SYNC && ctrl_reg[`TCCP_CTRL_SYNC];
      assign own_clr = run && !comp &&
        (((clr_src == `TCCP_CLR_A) && (m[0] | c[0])) ||
         ((clr_src == `TCCP_CLR_B) && (m[1] | c[1])));
      assign clr_out[g] = own_clr & sync_mem[g];
      assign sync_in = |(clr_out & ~(5'h01 << g));
      assign ext_clr = run && !comp && sync_in && sync_mem[g] &&
        (clr_src == `TCCP_CLR_SYNC);
      assign cnt_wr[g] = wr_this && (sel_idx == `TCCP_IDX_CNT);
      // counter write to a sync member presets every sync member
      assign preset = cnt_wr[g] | (sync_mem[g] & |(cnt_wr & sync_mem));

      // Next counter value and overflow event
      always @* begin
        cnt_next = cnt_reg;
        down_next = down_reg;
        ovf_ev = 1'b0;
        if (preset) begin
          cnt_next = pwdata[15:0];
        end else if (own_clr || ext_clr) begin
          // zero on the clock after the match
          cnt_next = `TCCP_CNT_RST;
        end else if (run && comp) begin
          if (down_reg) begin
            cnt_next = cnt_reg - `TCCP_CNT_ONE;
            if (cnt_reg == `TCCP_CNT_ONE) begin
              ovf_ev = 1'b1;
              down_next = 1'b0;
            end
          end else if (cnt_reg == grs[15:0]) begin
            cnt_next = cnt_reg - `TCCP_CNT_ONE;
            down_next = 1'b1;
          end else begin
            cnt_next = cnt_reg + `TCCP_CNT_ONE;
          end
        end else if (run) begin
          cnt_next = cnt_reg + `TCCP_CNT_ONE;
          ovf_ev = (cnt_reg == `TCCP_CNT_MAX);
        end
      end

      // Hardware flag events; bit 2 never exists
      // compare match on D sets flag
      // no D flag outside channels 0, 3, 4
      assign set_vec = {ovf_ev, HAS_D ? (m[2] | c[2]) : 1'b0, 1'b0,
        m[1] | c[1], m[0] | c[0]};
      // clear needs zero written after a one was read
      assign clr_vec = {5{st_wr}} & ~pwdata[4:0] & arm_reg;

      // Control, counter, flags
      always @(posedge clk) begin
        if (rst) begin
          ctrl_reg <= `TCCP_CTRL_RST;
          cnt_reg <= `TCCP_CNT_RST;
          down_reg <= 1'b0;
          flag_reg <= `TCCP_ST_RST;
          arm_reg <= `TCCP_ST_RST;
        end else begin
          if (wr_this && (sel_idx == `TCCP_IDX_CTRL)) begin
            ctrl_reg <= pwdata[5:0] & CTRL_MASK;
          end
          cnt_reg <= cnt_next;
          down_reg <= comp ? down_next : 1'b0;
          // flag set wins over clear, same cycle as match
          flag_reg <= (flag_reg & ~clr_vec) | set_vec;
          // arm on a status read that returns ones
          if (rd_this && (sel_idx == `TCCP_IDX_STATUS)) begin
            arm_reg <= flag_reg;
          end else if (st_wr) begin
            arm_reg <= `TCCP_ST_RST;
          end
        end
      end

      // Register readback for this channel
      always @* begin
        case (sel_idx)
          `TCCP_IDX_CTRL: rd_reg_val = {10'h000, ctrl_reg};
          `TCCP_IDX_PAC: rd_reg_val = {4'h0, codes};
          `TCCP_IDX_STATUS: rd_reg_val = {11'h000, flag_reg};
          `TCCP_IDX_CNT: rd_reg_val = cnt_reg;
          `TCCP_IDX_GRA: rd_reg_val = grs[15:0];
          `TCCP_IDX_GRB: rd_reg_val = grs[31:16];
          `TCCP_IDX_GRD: rd_reg_val = grs[47:32];
          default: rd_reg_val = 16'h0000;
        endcase
      end
      assign ch_rd[16*g+15:16*g] = rd_reg_val;
    end
  endgenerate

endmodule
`default_nettype wire

// ===== test/tccp_monitor.sv
// Port checker for the timer group
`timescale 1ns/10ps
`default_nettype none
module tccp_monitor (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [14:0] pin_in,
  input wire [14:0] pin_out,
  input wire [14:0] pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire done = psel && penable && pready;
  wire wr3 = done && pwrite && paddr == 32'h0000_0064;
  reg lvl_reg;
  reg cap_reg;
  // Keep the level and mode last written for pin A of channel 3
  always @(posedge clk) begin
    if (wr3) begin
      lvl_reg <= pwdata[2];
      cap_reg <= pwdata[3];
    end
  end
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  wait_state_a: assert property (psel && penable && !$past(penable)
    |-> !pready ##1 pready) else $error("wrong wait state count");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  unmapped_err_a: assert property (pready && paddr[4:2] == 3'h7
    |-> pslverr) else $error("unmapped access not refused");
  upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  no_flag_d_a: assert property (
    pready && !pwrite && (paddr == 32'h0000_0028 ||
    paddr == 32'h0000_0048) |-> !prdata[3]) else $error("flag d read one");
  reset_pins_a: assert property (
    $past(rst) |-> pin_out == 15'h0000 && pin_oe == 15'h7fff)
    else $error("pins not low after reset");
  init_level_a: assert property (
    wr3 && !pwdata[3] && pwdata[1:0] != 2'b00
    |-> ##2 pin_out[9] == lvl_reg) else $error("wrong initial level");
  drive_en_a: assert property (
    wr3 |-> ##2 pin_oe[9] == !cap_reg) else $error("wrong pin drive");
  cover property (wr3 && !pwdata[3]);
  cover property (pslverr);
  cover property (done && !pwrite && paddr == 32'h0000_0088);
endmodule
bind tccp_timer_group tccp_monitor chk (.clk, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in,
  .pin_out, .pin_oe);
`default_nettype wire

// ===== test/tccp_pin_model.sv
// Far side of the timer pins
`timescale 1ns/10ps
`default_nettype none
module tccp_pin_model (
  input wire [14:0] pin_out,
  input wire [14:0] pin_oe,
  input wire [14:0] ext_lvl,
  output wire [14:0] pin_in
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule
`default_nettype wire

// ===== test/test_timer_capture_compare_pwm.sv
// Self-checking bench for the timer group
`timescale 1ns/10ps
`default_nettype none
module test_timer_capture_compare_pwm;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [14:0] ext_lvl = '0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire [14:0] pin_in;
  wire [14:0] pin_out;
  wire [14:0] pin_oe;
  int fails = 0;
  int comparisons = 0;
  logic [31:0] rv;
  logic ev;

  tccp_timer_group uut (.clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe);
  tccp_pin_model far (.pin_out, .pin_oe, .ext_lvl, .pin_in);

  // Clock of 25 ns
  initial begin
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] ad(input int c, input int i);
    return 32'(c * 32 + i * 4);
  endfunction

  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // APB transfer held until pready is sampled high
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) begin
      fails++;
      $display("unexpected at %0t: no ready from slave", $time);
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input int c, input int i, input logic [31:0] d);
    apb(1'b1, ad(c, i), d);
  endtask

  task rd(input int c, input int i, input logic [31:0] e);
    apb(1'b0, ad(c, i), 32'h0000_0000);
    chk(rv, e);
  endtask

  task t_reset();
    rd(3, 1, 32'h0000_0000);
    rd(0, 2, 32'h0000_0000);
    rd(3, 4, 32'h0000_ffff);
    chk({17'h0, pin_out}, 32'h0000_0000);
    chk({17'h0, pin_oe}, 32'h0000_7fff);
    apb(1'b1, 32'h0000_00e0, 32'h0000_0001);
    chk({31'h0, ev}, 32'h0000_0001);
    $display("reset test done");
  endtask

  // Compare actions on channel 3 pins A, B, D, then flag clearing
  task t_compare();
    wr(3, 4, 32'h0000_0014);
    wr(3, 5, 32'h0000_0014);
    wr(3, 6, 32'h0000_0014);
    wr(3, 1, 32'h0000_0257);
    repeat (2) @(posedge clk);
    chk({29'h0, pin_out[11:9]}, 32'h0000_0003);
    wr(3, 0, 32'h0000_0020);
    repeat (40) @(posedge clk);
    chk({29'h0, pin_out[11:9]}, 32'h0000_0004);
    rd(3, 2, 32'h0000_000b);
    wr(3, 2, 32'h0000_001f);
    wr(3, 2, 32'h0000_0000);
    rd(3, 2, 32'h0000_000b);
    wr(3, 2, 32'h0000_0000);
    rd(3, 2, 32'h0000_0000);
    $display("compare test done");
  endtask

  // Wrap of channel 0 counter; general registers A, B, D still hold the maximum
  task t_overflow();
    wr(0, 3, 32'h0000_fff0);
    wr(0, 0, 32'h0000_0020);
    rd(0, 2, 32'h0000_0000);
    repeat (20) @(posedge clk);
    rd(0, 2, 32'h0000_001b);
    $display("overflow test done");
  endtask

  // Rising, falling and both-edge capture into channel 4 register D
  task t_capture();
    wr(3, 1, 32'h0000_0008);
    chk({31'h0, pin_oe[9]}, 32'h0000_0000);
    wr(4, 0, 32'h0000_0020);
    for (int k = 0; k < 3; k++) begin
      wr(4, 1, 32'(32'h0000_0800 + k * 256));
      ext_lvl[14] <= ~ext_lvl[14];
      repeat (4) @(posedge clk);
      rd(4, 2, 32'h0000_0008);
      wr(4, 2, 32'h0000_0000);
    end
    rd(4, 2, 32'h0000_0000);
    $display("capture test done");
  endtask

  // Channel 1 has no D flag; its idle pins keep low
  task t_no_flag();
    wr(1, 6, 32'h0000_0004);
    wr(1, 0, 32'h0000_0020);
    wr(1, 2, 32'h0000_0008);
    repeat (8) @(posedge clk);
    rd(1, 2, 32'h0000_0000);
    chk({29'h0, pin_out[5:3]}, 32'h0000_0000);
    $display("flag d test done");
  endtask

  // Channel 0 preset by a channel 1 counter write, channel 1 cleared by channel 0 B match
  task t_sync();
    wr(0, 0, 32'h0000_0006);
    rd(0, 2, 32'h0000_001b);
    wr(0, 2, 32'h0000_0000);
    wr(0, 5, 32'h0000_0020);
    wr(1, 0, 32'h0000_0007);
    wr(1, 4, 32'h0000_0030);
    wr(1, 3, 32'h0000_0011);
    rd(0, 3, 32'h0000_0011);
    wr(1, 0, 32'h0000_0027);
    wr(0, 0, 32'h0000_0026);
    repeat (100) @(posedge clk);
    rd(1, 2, 32'h0000_0000);
    rd(0, 2, 32'h0000_0002);
    $display("sync test done");
  endtask

  // PWM mode 1 on channel 2: period 10 cycles, pin A high for 6 of them
  task t_pwm();
    logic [31:0] hi;
    wr(2, 4, 32'h0000_0009);
    wr(2, 5, 32'h0000_0003);
    wr(2, 1, 32'h0000_0021);
    wr(2, 0, 32'h0000_0029);
    repeat (12) @(posedge clk);
    hi = 32'h0000_0000;
    repeat (40) begin
      @(posedge clk);
      hi = hi + pin_out[6];
    end
    chk(hi, 32'h0000_0018);
    $display("pwm test done");
  endtask

  // Channel 4 counts up to A, back down, and flags the step from one to zero
  task t_comp();
    wr(4, 0, 32'h0000_0000);
    wr(4, 4, 32'h0000_0008);
    wr(4, 3, 32'h0000_0000);
    wr(4, 0, 32'h0000_0030);
    repeat (30) @(posedge clk);
    rd(4, 2, 32'h0000_0011);
    $display("complementary test done");
  endtask

  task test_done();
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Reset, then the tests in turn
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_compare();
    t_overflow();
    t_capture();
    t_no_flag();
    t_sync();
    t_pwm();
    t_comp();
    test_done();
  end

  // Hang guard well past the expected run
  initial begin
    #(25 * 20000);
    fails++;
    $display("unexpected at %0t: run did not finish", $time);
    test_done();
  end
endmodule
`default_nettype wire
